// File: hdl/dmpi_pkg.sv
// Constants for the display memory pin interface.
// Assumes a single 200 MHz system clock and an active-high asynchronous reset.
package dmpi_pkg;
   // Bus widths
   localparam int ADDR_W = 9;
   localparam int DATA_W = 64;
   localparam int STRAP_W = 29;
   localparam int GDB_W = 24;
   localparam int CAS_W = 8;
   localparam int CFG_W = 8;
   // Configuration bit positions
   localparam int SEQA_RAS1_BIT = 6;
   localparam int MCFG_OE1_OFF_BIT = 2;
   localparam int FCC_ENABLE_BIT = 0;
   // Strobe idle level (all memory strobes are active low)
   localparam logic STROBE_IDLE = 1'h1;
   localparam logic [CAS_W-1:0] CAS_IDLE = 8'hff;
   // Strap settling window after reset release
   localparam int CLK_PERIOD_PS = 5000;
   localparam int STRAP_SETTLE_NS = 50;
   localparam int STRAP_CYCLES = (STRAP_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int STRAP_CNT_W = 8;
endpackage

// File: hdl/dmpi_strap_capture.sv
// Strap capture: samples the low pixel data lines once after reset release.
// Assumes the pixel data pins are undriven by the device until capture completes.
module dmpi_strap_capture #(
   parameter int STRAP_WIDTH = dmpi_pkg::STRAP_W,
   parameter int SETTLE_CYCLES = dmpi_pkg::STRAP_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [STRAP_WIDTH-1:0] strap_pins,
   output logic [STRAP_WIDTH-1:0] straps,
   output logic strap_done
);
   localparam int CNT_W = dmpi_pkg::STRAP_CNT_W;
   logic [CNT_W-1:0] settle_count;
   logic settle_end;

   // Pull-ups and pull-downs need time to settle after reset drops
   assign settle_end = (settle_count == CNT_W'(SETTLE_CYCLES - 1));

   // Settle counter stops at SETTLE_CYCLES - 1, the cycle before straps are taken
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         settle_count <= '0;
      end else if (!strap_done && !settle_end) begin
         settle_count <= settle_count + 1'b1;
      end
   end

   // Clocked capture after release, never inside the reset branch
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         straps <= '0;
         strap_done <= 1'b0;
      end else if (!strap_done && settle_end) begin
         straps <= strap_pins;
         strap_done <= 1'b1;
      end
   end

   sequence s_settled;
      !strap_done ##1 strap_done;
   endsequence

   a_strap_once: assert property (@(posedge clk_sys) disable iff (rst) strap_done |=> strap_done)
      else $error("strap done dropped");
   a_strap_value: assert property (@(posedge clk_sys) disable iff (rst)
      s_settled |-> straps == $past(strap_pins))
      else $error("straps not taken from pins");
endmodule

// File: hdl/dmpi_pin_interface.sv
// Display memory pin interface: address mux, pixel data pins, strobes, shared pin.
// Assumes a memory sequencer drives row/column, data and raw strobes synchronously.
// Functional notes
// - Row and column addresses time-multiplexed on nine address outputs.
// - 64-line pixel data bus driven on writes, received on reads.
// - Low 29 pixel data lines sampled as configuration straps after reset.
// - Eight separate column strobes driven to memory.
// - PCI host: second row strobe on shared pin only if sequencer bit 6.
// - Second output enable on shared pin when memory config bit 2 clear.
// - Feature connector disabled: second output enable copies the first.
// - VL host with peripheral port: second output enable unavailable.
module dmpi_pin_interface #(
   parameter int ADDR_WIDTH = dmpi_pkg::ADDR_W,
   parameter int DATA_WIDTH = dmpi_pkg::DATA_W,
   parameter int GDB_WIDTH = dmpi_pkg::GDB_W,
   parameter int CAS_WIDTH = dmpi_pkg::CAS_W
) (
   input wire logic clk_sys,
   input wire logic rst,
   // Sequencer side
   input wire logic [ADDR_WIDTH-1:0] row_address,
   input wire logic [ADDR_WIDTH-1:0] col_address,
   input wire logic col_select,
   input wire logic [DATA_WIDTH-1:0] write_data,
   input wire logic write_drive,
   output logic [DATA_WIDTH-1:0] read_data,
   input wire logic [1:0] ras_n_int,
   input wire logic [CAS_WIDTH-1:0] cas_n_int,
   input wire logic we_n_int,
   input wire logic [1:0] oe_n_int,
   // General data bus side
   input wire logic gdb_select,
   input wire logic [GDB_WIDTH-1:0] gdb_write,
   input wire logic gdb_drive,
   output logic [GDB_WIDTH-1:0] gdb_read,
   // Configuration
   input wire logic [dmpi_pkg::CFG_W-1:0] sequencer_control_a,
   input wire logic [dmpi_pkg::CFG_W-1:0] feature_conn_control,
   input wire logic [dmpi_pkg::CFG_W-1:0] memory_config_reg,
   input wire logic host_is_pci,
   input wire logic local_peripheral_port,
   output logic [dmpi_pkg::STRAP_W-1:0] straps,
   output logic strap_done,
   output logic shared_conflict,
   output logic ras1_active,
   // Memory pins
   output logic [ADDR_WIDTH-1:0] dram_mux_address,
   input wire logic [DATA_WIDTH-1:0] pixel_data_bus_in,
   output logic [DATA_WIDTH-1:0] pixel_data_bus_out,
   output logic [DATA_WIDTH-1:0] pixel_data_bus_oe,
   output logic ras0_n,
   output logic [CAS_WIDTH-1:0] cas_n,
   output logic we_n,
   output logic oe0_n,
   output logic shared_pin_n,
   output logic shared_pin_oe
);
   logic [DATA_WIDTH-1:0] next_pd_out;
   logic [DATA_WIDTH-1:0] next_pd_oe;
   logic ras1_allow;
   logic oe1_allow;
   logic oe1_value;

   // Straps are read from the pins before the device ever drives them
   dmpi_strap_capture #(
      .STRAP_WIDTH(dmpi_pkg::STRAP_W),
      .SETTLE_CYCLES(dmpi_pkg::STRAP_CYCLES)
   ) u_strap (
      .clk_sys(clk_sys),
      .rst(rst),
      .strap_pins(pixel_data_bus_in[dmpi_pkg::STRAP_W-1:0]),
      .straps(straps),
      .strap_done(strap_done)
   );

   // Address mux, registered so row and column never glitch on the pins
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dram_mux_address <= '0;
      end else begin
         dram_mux_address <= col_select ? col_address : row_address;
      end
   end

   // Per-pin source and drive; low pins carry the general bus when selected
   for (genvar i = 0; i < DATA_WIDTH; i++) begin : g_pd
      if (i < GDB_WIDTH) begin : g_shared
         assign next_pd_out[i] = gdb_select ? gdb_write[i] : write_data[i];
         assign next_pd_oe[i] = strap_done & (gdb_select ? gdb_drive : write_drive);
      end else begin : g_mem
         assign next_pd_out[i] = write_data[i];
         assign next_pd_oe[i] = strap_done & write_drive & ~gdb_select;
      end
   end

   // Pixel data drive; enables stay off until straps are taken
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pixel_data_bus_out <= '0;
         pixel_data_bus_oe <= '0;
      end else begin
         pixel_data_bus_out <= next_pd_out;
         pixel_data_bus_oe <= next_pd_oe;
      end
   end

   // Read capture from the pins
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         read_data <= '0;
         gdb_read <= '0;
      end else begin
         read_data <= pixel_data_bus_in;
         gdb_read <= pixel_data_bus_in[GDB_WIDTH-1:0];
      end
   end

   // Dedicated strobes; held idle during the strap window
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ras0_n <= dmpi_pkg::STROBE_IDLE;
         cas_n <= dmpi_pkg::CAS_IDLE;
         we_n <= dmpi_pkg::STROBE_IDLE;
         oe0_n <= dmpi_pkg::STROBE_IDLE;
      end else if (!strap_done) begin
         ras0_n <= dmpi_pkg::STROBE_IDLE;
         cas_n <= dmpi_pkg::CAS_IDLE;
         we_n <= dmpi_pkg::STROBE_IDLE;
         oe0_n <= dmpi_pkg::STROBE_IDLE;
      end else begin
         ras0_n <= ras_n_int[0];
         cas_n <= cas_n_int;
         we_n <= we_n_int;
         oe0_n <= oe_n_int[0];
      end
   end

   // Shared pin function select; row strobe wins so a bad setup never fights
   assign ras1_allow = host_is_pci & sequencer_control_a[dmpi_pkg::SEQA_RAS1_BIT];
   assign oe1_allow = ~memory_config_reg[dmpi_pkg::MCFG_OE1_OFF_BIT]
      & ~(~host_is_pci & local_peripheral_port)
      & ~ras1_allow;
   assign oe1_value = feature_conn_control[dmpi_pkg::FCC_ENABLE_BIT] ? oe_n_int[1] : oe_n_int[0];

   // Shared pin drive, one function at a time
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         shared_pin_n <= dmpi_pkg::STROBE_IDLE;
         shared_pin_oe <= 1'b0;
         ras1_active <= 1'b0;
      end else begin
         shared_pin_oe <= strap_done & (ras1_allow | oe1_allow);
         ras1_active <= ras1_allow;
         if (!strap_done) begin
            shared_pin_n <= dmpi_pkg::STROBE_IDLE;
         end else if (ras1_allow) begin
            shared_pin_n <= ras_n_int[1];
         end else begin
            shared_pin_n <= oe1_value;
         end
      end
   end

   // Flags a setup that asks for both shared functions at once
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         shared_conflict <= 1'b0;
      end else begin
         shared_conflict <= ras1_allow & ~memory_config_reg[dmpi_pkg::MCFG_OE1_OFF_BIT];
      end
   end

   sequence s_ready;
      strap_done ##1 strap_done;
   endsequence

   a_addr_mux: assert property (@(posedge clk_sys) disable iff (rst)
      1'b1 |=> dram_mux_address == ($past(col_select) ? $past(col_address) : $past(row_address)))
      else $error("address mux wrong");
   a_pd_write: assert property (@(posedge clk_sys) disable iff (rst)
      s_ready ##0 (write_drive && !gdb_select) |=> pixel_data_bus_oe == '1 && pixel_data_bus_out == $past(write_data))
      else $error("write data not driven");
   a_strap_quiet: assert property (@(posedge clk_sys) disable iff (rst)
      !strap_done |=> pixel_data_bus_oe == '0 || $past(strap_done))
      else $error("pins driven during strap window");
   a_gdb_share: assert property (@(posedge clk_sys) disable iff (rst)
      strap_done && gdb_select && gdb_drive |=> pixel_data_bus_out[GDB_WIDTH-1:0] == $past(gdb_write)
      && pixel_data_bus_oe[DATA_WIDTH-1:GDB_WIDTH] == '0)
      else $error("general bus not on shared pins");
   a_gdb_read: assert property (@(posedge clk_sys) disable iff (rst)
      1'b1 |=> gdb_read == $past(pixel_data_bus_in[GDB_WIDTH-1:0]))
      else $error("general bus read not captured");
   a_rd_capture: assert property (@(posedge clk_sys) disable iff (rst)
      1'b1 |=> read_data == $past(pixel_data_bus_in))
      else $error("read data not captured");
   a_cas_follow: assert property (@(posedge clk_sys) disable iff (rst)
      strap_done |=> cas_n == $past(cas_n_int))
      else $error("column strobes not following");
   a_ras1_pci: assert property (@(posedge clk_sys) disable iff (rst)
      strap_done && host_is_pci && sequencer_control_a[dmpi_pkg::SEQA_RAS1_BIT]
      |=> shared_pin_oe && shared_pin_n == $past(ras_n_int[1]))
      else $error("second row strobe missing");
   a_ras1_vl: assert property (@(posedge clk_sys) disable iff (rst)
      !host_is_pci |=> !ras1_active)
      else $error("row strobe on VL host");
   a_oe1_sel: assert property (@(posedge clk_sys) disable iff (rst)
      strap_done && !ras1_allow && memory_config_reg[dmpi_pkg::MCFG_OE1_OFF_BIT] |=> !shared_pin_oe)
      else $error("output enable driven while off");
   a_oe1_copy: assert property (@(posedge clk_sys) disable iff (rst)
      strap_done && oe1_allow && !feature_conn_control[dmpi_pkg::FCC_ENABLE_BIT]
      |=> shared_pin_oe && shared_pin_n == $past(oe_n_int[0]))
      else $error("output enable copy wrong");
   a_lpp_block: assert property (@(posedge clk_sys) disable iff (rst)
      !host_is_pci && local_peripheral_port |=> !shared_pin_oe)
      else $error("shared pin driven with peripheral port");
   a_shared_one: assert property (@(posedge clk_sys) disable iff (rst)
      ras1_allow && !memory_config_reg[dmpi_pkg::MCFG_OE1_OFF_BIT] && strap_done
      |=> shared_conflict && shared_pin_n == $past(ras_n_int[1]))
      else $error("shared pin conflict not resolved");
endmodule

// File: tb/dmpi_dram_model.sv
// Behavioural video DRAM bank with strap resistors on the pixel data lines.
// Assumes the bench resolves the pins from this drive and the device's enables.
module dmpi_dram_model #(
   parameter logic [63:0] STRAP_VALUE = 64'h0000_0000_1a5c_3e97
) (
   input wire logic clk_sys,
   input wire logic oe_n,
   input wire logic [63:0] mem_word,
   output logic [63:0] drive
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [63:0] last = 64'h0;
   // Read data while enabled; released lines 63 to 29 never hold the last value
   always_comb begin
      if (!oe_n) begin
         drive = mem_word;
      end else begin
         drive = {~last[63:29], STRAP_VALUE[28:0]};
      end
   end
   // Track the last word driven so released lines 63 to 29 show its inverse
   always @(posedge clk_sys) begin
      if (!oe_n) begin
         last <= drive;
      end
   end
endmodule

// File: tb/dmpi_pin_interface_tb_top.sv
// Bench for the pin interface: strap capture, address, data, strobes, shared pin.
// Assumes the default strap settle count of the design.
module dmpi_pin_interface_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [63:0] STRAPV = 64'h0000_0000_1a5c_3e97;
   localparam logic [63:0] MEMV = 64'hc3a5_0f1e_7788_9abc;
   logic clk_sys = 1'h0, rst = 1'h1, col_select = 1'h0, write_drive = 1'h0, we_n_int = 1'h1;
   logic gdb_select = 1'h0, gdb_drive = 1'h0, host_is_pci = 1'h0, local_peripheral_port = 1'h0;
   logic [8:0] row_address = 9'h000, col_address = 9'h000;
   logic [63:0] write_data = 64'h0, read_data, pd_in, pd_out, pd_oe, model_drive;
   logic [1:0] ras_n_int = 2'h0, oe_n_int = 2'h3;
   logic [7:0] cas_n_int = 8'h00, seqa = 8'h00, fcc = 8'h00, mcfg = 8'h00, cas_n;
   logic [23:0] gdb_write = 24'h0, gdb_read;
   logic [28:0] straps;
   logic strap_done, shared_conflict, ras1_active, ras0_n, we_n, oe0_n, shared_pin_n, shared_pin_oe;
   logic [8:0] dram_mux_address;
   int n_errors = 0, total_checks = 0;
   always #2.5 clk_sys = ~clk_sys;
   // Resolve each pixel line from both drivers
   assign pd_in = (pd_oe & pd_out) | (~pd_oe & model_drive);
   dmpi_pin_interface DUT (.clk_sys(clk_sys), .rst(rst), .row_address(row_address),
      .col_address(col_address), .col_select(col_select), .write_data(write_data),
      .write_drive(write_drive), .read_data(read_data), .ras_n_int(ras_n_int), .cas_n_int(cas_n_int),
      .we_n_int(we_n_int), .oe_n_int(oe_n_int), .gdb_select(gdb_select), .gdb_write(gdb_write),
      .gdb_drive(gdb_drive), .gdb_read(gdb_read), .sequencer_control_a(seqa), .feature_conn_control(fcc),
      .memory_config_reg(mcfg), .host_is_pci(host_is_pci), .local_peripheral_port(local_peripheral_port),
      .straps(straps), .strap_done(strap_done), .shared_conflict(shared_conflict), .ras1_active(ras1_active),
      .dram_mux_address(dram_mux_address), .pixel_data_bus_in(pd_in), .pixel_data_bus_out(pd_out),
      .pixel_data_bus_oe(pd_oe), .ras0_n(ras0_n), .cas_n(cas_n), .we_n(we_n), .oe0_n(oe0_n),
      .shared_pin_n(shared_pin_n), .shared_pin_oe(shared_pin_oe));
   dmpi_dram_model #(.STRAP_VALUE(STRAPV)) mem0 (.clk_sys(clk_sys), .oe_n(oe0_n), .mem_word(MEMV),
      .drive(model_drive));
   // The given number of edges pass, inputs then move a fixed delay later
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Watchdog sized well past the whole sequence
   initial begin
      #20000;
      n_errors++;
      report_and_stop();
   end
   initial begin
      logic pci, s6, m2, lpp, fc, ra, oa;
      step(20);
      rst = 1'h0;
      step(3);
      chk("cas idle", {56'h0, dmpi_pkg::CAS_IDLE}, {56'h0, cas_n});
      chk("pd oe early", 64'h0, pd_oe);
      step(dmpi_pkg::STRAP_CYCLES - 4);
      chk("strap early", 64'h0, {63'h0, strap_done});
      step(1);
      chk("strap done", 64'h1, {63'h0, strap_done});
      chk("straps", {35'h0, STRAPV[28:0]}, {35'h0, straps});
      $display("test reset done");
      row_address = 9'h1a5;
      col_address = 9'h05a;
      step(1);
      chk("row addr", {55'h0, 9'h1a5}, {55'h0, dram_mux_address});
      col_select = 1'h1;
      cas_n_int = 8'h96;
      step(1);
      chk("col addr", {55'h0, 9'h05a}, {55'h0, dram_mux_address});
      chk("cas pass", 64'h96, {56'h0, cas_n});
      write_drive = 1'h1;
      we_n_int = 1'h0;
      write_data = 64'h1234_5678_9abc_def0;
      step(1);
      chk("wr oe", {64{1'h1}}, pd_oe);
      chk("wr data", 64'h1234_5678_9abc_def0, pd_out);
      chk("we low", 64'h0, {63'h0, we_n});
      chk("ras0 low", 64'h0, {63'h0, ras0_n});
      write_drive = 1'h0;
      we_n_int = 1'h1;
      oe_n_int = 2'h2;
      step(2);
      chk("rd data", MEMV, read_data);
      chk("oe0 low", 64'h0, {63'h0, oe0_n});
      chk("we high", 64'h1, {63'h0, we_n});
      gdb_select = 1'h1;
      gdb_drive = 1'h1;
      gdb_write = 24'h5a3c96;
      step(1);
      chk("gdb out", {40'h0, 24'h5a3c96}, {40'h0, pd_out[23:0]});
      chk("gdb upper oe", 64'h0, {24'h0, pd_oe[63:24]});
      chk("gdb low oe", {40'h0, 24'hffffff}, {40'h0, pd_oe[23:0]});
      step(1);
      chk("gdb read", {40'h0, 24'h5a3c96}, {40'h0, gdb_read});
      gdb_select = 1'h0;
      gdb_drive = 1'h0;
      $display("test data done");
      ras_n_int = 2'h1;
      // Every combination of host, configuration bits and port
      for (int i = 0; i < 32; i++) begin
         {pci, s6, m2, lpp, fc} = i[4:0];
         host_is_pci = pci;
         local_peripheral_port = lpp;
         seqa = {1'h0, s6, 6'h00};
         mcfg = {5'h00, m2, 2'h0};
         fcc = {7'h00, fc};
         ra = pci & s6;
         oa = !m2 && !(!pci && lpp) && !ra;
         step(1);
         chk("ras1 active", {63'h0, ra}, {63'h0, ras1_active});
         chk("shared oe", {63'h0, ra | oa}, {63'h0, shared_pin_oe});
         chk("conflict", {63'h0, ra & !m2}, {63'h0, shared_conflict});
         if (ra) chk("shared ras1", 64'h0, {63'h0, shared_pin_n});
         if (oa) chk("shared oe1", {63'h0, fc}, {63'h0, shared_pin_n});
      end
      $display("test shared pin done");
      // Second reset in mid-run: straps must be taken again after the settle window
      rst = 1'h1;
      step(2);
      chk("strap reset", 64'h0, {63'h0, strap_done});
      chk("straps reset", 64'h0, {35'h0, straps});
      chk("shared oe reset", 64'h0, {63'h0, shared_pin_oe});
      chk("pd oe reset", 64'h0, pd_oe);
      chk("rd reset", 64'h0, read_data);
      rst = 1'h0;
      step(dmpi_pkg::STRAP_CYCLES - 1);
      chk("strap wait", 64'h0, {63'h0, strap_done});
      chk("shared oe wait", 64'h0, {63'h0, shared_pin_oe});
      step(1);
      chk("strap again", 64'h1, {63'h0, strap_done});
      chk("straps again", {35'h0, STRAPV[28:0]}, {35'h0, straps});
      $display("test second reset done");
      report_and_stop();
   end
endmodule
